// [pkg/ccu_pkg.sv]
package ccu_pkg;

  // Register indexes on the plain port
  localparam logic [2:0] ADDR_CTRL     = 3'h0;
  localparam logic [2:0] ADDR_DUTY_HI  = 3'h1;
  localparam logic [2:0] ADDR_CAP_LO   = 3'h2;
  localparam logic [2:0] ADDR_CAP_HI   = 3'h3;
  localparam logic [2:0] ADDR_CMP_LO   = 3'h4;
  localparam logic [2:0] ADDR_CMP_HI   = 3'h5;
  localparam logic [2:0] ADDR_FLAG     = 3'h6;
  localparam logic [2:0] ADDR_STATUS   = 3'h7;

  // Control register fields
  localparam int MODE_LSB   = 0;
  localparam int DUTY_LSB   = 4;
  localparam logic [7:0] CTRL_RST     = 8'h00;
  localparam logic [7:0] DUTY_HI_RST  = 8'h00;
  localparam logic [15:0] CMP_RST     = 16'h0000;
  localparam logic [7:0] CTRL_WMASK   = 8'h3F;

  // Prescale terminal counts
  localparam logic [3:0] PRE_DIV4_LAST  = 4'h3;
  localparam logic [3:0] PRE_DIV16_LAST = 4'hF;

  typedef enum logic [3:0] {
    CCU_MODE_OFF      = 4'b0000,
    CCU_MODE_RSV1     = 4'b0001,
    CCU_MODE_RSV2     = 4'b0010,
    CCU_MODE_RSV3     = 4'b0011,
    CCU_MODE_CAP_FALL = 4'b0100,
    CCU_MODE_CAP_RISE = 4'b0101,
    CCU_MODE_CAP_4    = 4'b0110,
    CCU_MODE_CAP_16   = 4'b0111,
    CCU_MODE_CMP_SET  = 4'b1000,
    CCU_MODE_CMP_CLR  = 4'b1001,
    CCU_MODE_CMP_SW   = 4'b1010,
    CCU_MODE_CMP_TRIG = 4'b1011
  } ccu_mode_t;

endpackage

// [pkg/ccu_cap_if.sv]
`timescale 1ns/1ns
interface ccu_cap_if;
  logic [3:0] mode;
  logic       pin_sync;
  logic       cap_strobe;
  modport edge_side (input mode, input pin_sync, output cap_strobe);
  modport ctrl_side (output mode, output pin_sync, input cap_strobe);
endinterface

// [src/ccu_sync.sv]
`timescale 1ns/1ns
module ccu_sync (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  // Pin level
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_r;
  logic sync_r;

  // First stage is read only by the second
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule // ccu_sync

// [src/ccu_edge.sv]
`timescale 1ns/1ns
module ccu_edge (
  // Clock and reset
  input  wire logic  clk_in,
  input  wire logic  sys_rst_in,
  // Mode and strobe
  ccu_cap_if.edge_side cap
);
  logic       prev_r;
  logic [3:0] pre_r;
  logic [3:0] pre_nxt;
  logic       rise;
  logic       fall;
  logic       is_cap;
  logic       hit;

  assign rise   = cap.pin_sync & ~prev_r;
  assign fall   = ~cap.pin_sync & prev_r;
  assign is_cap = (cap.mode[3:2] == 2'b01);

  // Prescaler keeps its count across prescale changes
  assign hit = !is_cap ? 1'b0 :
               (cap.mode == ccu_pkg::CCU_MODE_CAP_FALL) ? fall :
               (cap.mode == ccu_pkg::CCU_MODE_CAP_RISE) ? rise :
               (cap.mode == ccu_pkg::CCU_MODE_CAP_4) ?
                 (rise && pre_r[1:0] == ccu_pkg::PRE_DIV4_LAST[1:0]) :
                 (rise && pre_r == ccu_pkg::PRE_DIV16_LAST);

  assign pre_nxt = !is_cap ? 4'h0 : (rise ? pre_r + 4'h1 : pre_r);

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prev_r         <= 1'b0;
      pre_r          <= 4'h0;
      cap.cap_strobe <= 1'b0;
    end else begin
      prev_r         <= cap.pin_sync;
      pre_r          <= pre_nxt;
      cap.cap_strobe <= hit;
    end
  end

  a_div4_wraps: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (cap.mode == ccu_pkg::CCU_MODE_CAP_4 && hit) |=> cap.cap_strobe && pre_r[1:0] == 2'b00)
    else $error("divide by four capture did not strobe and wrap");
  a_pre_cleared: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !is_cap |=> pre_r == 4'h0)
    else $error("prescaler not cleared outside capture");
endmodule // ccu_edge

// [src/ccu_top.sv]
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ns
// Behaviour
// - PWM duty: two low bits plus duty-high
// - Mode 0000 disables unit and clears compare and prescale state
// - 0100 falling, 0101 rising edge capture
// - 0110 every 4th, 0111 every 16th
// - 1000 sets output high on match
// - 1001 drives output low on match
// - 1010 flag only, pin untouched
// - 1011 flag, timer reset, converter start
// - Capture copies full 16-bit timer count
// - Each capture sets the event flag
// - New capture overwrites old, no overrun
// - Edges seen even when pin drives
// - Prescaler cleared when off or reset
// - Trigger now, timer reset next tick
module ccu_top (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // Register port
  input  wire logic [2:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  // Shared timer
  input  wire logic [15:0] timer_count_in,
  input  wire logic        timer_tick_in,
  input  wire logic        adc_enabled_in,
  output logic             timer_reset_out,
  output logic             special_trig_out,
  output logic             adc_start_out,
  // Event pin
  input  wire logic        pin_in,
  input  wire logic        port_latch_in,
  output logic             pin_out,
  output logic             pin_owned_out,
  // PWM duty value and event flag
  output logic      [9:0]  pwm_duty_out,
  output logic             event_flag_out
);
  logic [7:0]  ctrl_r;
  logic [7:0]  duty_hi_r;
  logic [15:0] cap_r;
  logic [15:0] cmp_r;
  logic        flag_r;
  logic        cmp_latch_r;
  logic        trig_pend_r;
  logic        trig_r;
  logic        trst_r;
  logic        adc_r;
  logic        pin_r;
  logic        own_r;
  logic [9:0]  duty_r;
  logic [7:0]  rdata_r;
  logic        match_d_r;

  logic [3:0]  mode;
  logic        mode_off;
  logic        is_cmp;
  logic        match;
  logic        match_rise;
  logic        set_hit;
  logic        clr_hit;
  logic        trig_hit;
  logic        cap_evt;
  logic        cmp_evt;
  logic        wr_ctrl;
  logic        wr_flag;
  logic        flag_nxt;
  logic        drives_pin;
  logic        pin_sync;
  logic [7:0]  rd_mux;

  // One decode for every compare action keeps the mode tests in step
  function automatic logic act_on(input logic       rise_in,
                                  input logic [3:0] mode_in,
                                  input logic [3:0] want_in);
    return rise_in && (mode_in == want_in);
  endfunction

  ccu_cap_if cap_bus ();

  ccu_sync u_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (pin_in),
    .sync_out   (pin_sync)
  );

  assign cap_bus.mode     = mode;
  assign cap_bus.pin_sync = pin_sync;

  ccu_edge u_edge (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .cap        (cap_bus)
  );

  assign mode       = ctrl_r[ccu_pkg::MODE_LSB +: 4];
  assign mode_off   = (mode == ccu_pkg::CCU_MODE_OFF);
  assign is_cmp     = (mode[3:2] == 2'b10);
  assign match      = is_cmp && (timer_count_in == cmp_r);
  assign match_rise = match && !match_d_r;
  assign cap_evt    = cap_bus.cap_strobe;
  assign cmp_evt    = match_rise;
  assign set_hit    = act_on(match_rise, mode, ccu_pkg::CCU_MODE_CMP_SET);
  assign clr_hit    = act_on(match_rise, mode, ccu_pkg::CCU_MODE_CMP_CLR);
  assign trig_hit   = act_on(match_rise, mode, ccu_pkg::CCU_MODE_CMP_TRIG);
  assign wr_ctrl    = reg_wr_in && (reg_addr_in == ccu_pkg::ADDR_CTRL);
  assign wr_flag    = reg_wr_in && (reg_addr_in == ccu_pkg::ADDR_FLAG);
  assign drives_pin = (mode == ccu_pkg::CCU_MODE_CMP_SET) ||
                      (mode == ccu_pkg::CCU_MODE_CMP_CLR);

  // Hardware set wins over a software clear in the same cycle
  assign flag_nxt = (cap_evt || cmp_evt) ? 1'b1 :
                    wr_flag ? reg_wdata_in[0] : flag_r;

  assign rd_mux =
    (reg_addr_in == ccu_pkg::ADDR_CTRL)    ? (ctrl_r & ccu_pkg::CTRL_WMASK) :
    (reg_addr_in == ccu_pkg::ADDR_DUTY_HI) ? duty_hi_r :
    (reg_addr_in == ccu_pkg::ADDR_CAP_LO)  ? cap_r[7:0] :
    (reg_addr_in == ccu_pkg::ADDR_CAP_HI)  ? cap_r[15:8] :
    (reg_addr_in == ccu_pkg::ADDR_CMP_LO)  ? cmp_r[7:0] :
    (reg_addr_in == ccu_pkg::ADDR_CMP_HI)  ? cmp_r[15:8] :
    (reg_addr_in == ccu_pkg::ADDR_FLAG)    ? {7'h00, flag_r} :
                                             {5'h00, trig_pend_r, cmp_latch_r, own_r};

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_r    <= ccu_pkg::CTRL_RST;
      duty_hi_r <= ccu_pkg::DUTY_HI_RST;
      cmp_r     <= ccu_pkg::CMP_RST;
      rdata_r   <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= reg_wdata_in & ccu_pkg::CTRL_WMASK;
      end
      if (reg_wr_in && reg_addr_in == ccu_pkg::ADDR_DUTY_HI) begin
        duty_hi_r <= reg_wdata_in;
      end
      if (reg_wr_in && reg_addr_in == ccu_pkg::ADDR_CMP_LO) begin
        cmp_r[7:0] <= reg_wdata_in;
      end
      if (reg_wr_in && reg_addr_in == ccu_pkg::ADDR_CMP_HI) begin
        cmp_r[15:8] <= reg_wdata_in;
      end
      rdata_r <= reg_rd_in ? rd_mux : 8'h00;
    end
  end

  // Capture path; a later event simply overwrites
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cap_r  <= 16'h0000;
      flag_r <= 1'b0;
    end else begin
      if (cap_evt) begin
        cap_r <= timer_count_in;
      end
      flag_r <= flag_nxt;
    end
  end

  // Compare actions; off state drops every latch
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cmp_latch_r <= 1'b0;
      match_d_r   <= 1'b0;
      trig_pend_r <= 1'b0;
      trig_r      <= 1'b0;
      trst_r      <= 1'b0;
      adc_r       <= 1'b0;
    end else if (mode_off) begin
      cmp_latch_r <= 1'b0;
      match_d_r   <= 1'b0;
      trig_pend_r <= 1'b0;
      trig_r      <= 1'b0;
      trst_r      <= 1'b0;
      adc_r       <= 1'b0;
    end else begin
      match_d_r <= match;
      if (set_hit) begin
        cmp_latch_r <= 1'b1;
      end else if (clr_hit) begin
        cmp_latch_r <= 1'b0;
      end
      trig_r <= trig_hit;
      adc_r  <= trig_hit
                && adc_enabled_in;
      // Losing the match before the tick cancels the timer reset
      if (trig_hit) begin
        trig_pend_r <= 1'b1;
      end else if (timer_tick_in || !match) begin
        trig_pend_r <= 1'b0;
      end
      trst_r <= trig_pend_r && match && timer_tick_in;
    end
  end

  // Pin, ownership and duty outputs
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_r  <= 1'b0;
      own_r  <= 1'b0;
      duty_r <= 10'h000;
    end else begin
      own_r  <= drives_pin;
      pin_r  <= drives_pin ? cmp_latch_r : port_latch_in;
      duty_r <= {duty_hi_r, ctrl_r[ccu_pkg::DUTY_LSB +: 2]};
    end
  end

  assign reg_rdata_out    = rdata_r;
  assign timer_reset_out  = trst_r;
  assign special_trig_out = trig_r;
  assign adc_start_out    = adc_r;
  assign pin_out          = pin_r;
  assign pin_owned_out    = own_r;
  assign pwm_duty_out     = duty_r;
  assign event_flag_out   = flag_r;

  // Capture path and event flag
  a_cap_sets_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    cap_evt |=> flag_r && cap_r == $past(timer_count_in))
    else $error("capture did not load count and flag together");
  a_cap_holds: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !cap_evt |=> cap_r == $past(cap_r))
    else $error("capture register changed without event");
  a_flag_sticky: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (flag_r && !wr_flag) |=> flag_r)
    else $error("flag dropped without software clear");
  a_sw_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (wr_flag && !reg_wdata_in[0] && !cap_evt && !cmp_evt) |=> !event_flag_out)
    else $error("software clear of the flag ignored");
  a_cap_in_cap: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    cap_evt |-> $past(mode[3:2]) == 2'b01)
    else $error("capture strobe outside capture modes");
  a_one_strobe: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    cap_evt |=> !cap_evt)
    else $error("one edge gave two capture strobes");
  a_off_no_cap: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    mode_off |=> !cap_evt)
    else $error("off mode still captured");
  a_rsv_idle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (mode[3:2] == 2'b00) |=> !cap_evt && !special_trig_out)
    else $error("off or reserved mode produced an event");
  // Compare actions; pulses must stay single so the timer resets once
  a_off_clears: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    mode_off |=> !cmp_latch_r && !trig_r && !trig_pend_r)
    else $error("off mode left compare state");
  a_off_release: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    mode_off |=> !pin_owned_out)
    else $error("off mode kept the pin");
  a_set_high: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (match_rise && mode == ccu_pkg::CCU_MODE_CMP_SET) |=> ##1 pin_out)
    else $error("set mode did not drive pin high");
  a_set_holds: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (cmp_latch_r && mode == ccu_pkg::CCU_MODE_CMP_SET) |=> cmp_latch_r)
    else $error("set mode lost its output latch");
  a_clr_low: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (match_rise && mode == ccu_pkg::CCU_MODE_CMP_CLR) |=> ##1 !pin_out)
    else $error("clear mode did not drive pin low");
  a_cmp_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    cmp_evt |=> event_flag_out)
    else $error("compare match did not set the flag");
  a_sw_no_pin: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (mode == ccu_pkg::CCU_MODE_CMP_SW && $stable(mode)) |=> !pin_owned_out)
    else $error("software event mode took the pin");
  a_port_passes: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !drives_pin |=> pin_out == $past(port_latch_in))
    else $error("port latch not passed to the pin");
  a_trig_no_pin: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (mode == ccu_pkg::CCU_MODE_CMP_TRIG) |=> !pin_owned_out)
    else $error("trigger mode took the pin");
  a_trig_now: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (match_rise && mode == ccu_pkg::CCU_MODE_CMP_TRIG) |=> special_trig_out)
    else $error("trigger not immediate");
  a_trig_pulse: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    special_trig_out |=> !special_trig_out)
    else $error("trigger longer than one cycle");
  a_adc_with_trig: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    adc_start_out |-> special_trig_out)
    else $error("converter start without trigger");
  a_adc_needs_en: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    adc_start_out |-> $past(adc_enabled_in))
    else $error("converter started while disabled");
  a_trst_on_tick: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    timer_reset_out |-> $past(timer_tick_in))
    else $error("timer reset without a timer tick");
  a_trst_not_now: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    trig_hit |=> !timer_reset_out)
    else $error("timer reset came with the trigger");
  a_duty_word: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    1'b1 |=> pwm_duty_out == {$past(duty_hi_r), $past(ctrl_r[5:4])})
    else $error("duty value mismatch");
endmodule // ccu_top

// [verif/ccu_pin_src.sv]
`timescale 1ns/1ns
module ccu_pin_src (
  // Clock
  input  wire logic       clk_in,
  // Pulse train request
  input  wire logic       start_in,
  input  wire logic [4:0] count_in,
  input  wire logic [3:0] width_in,
  // Event pin drive
  output logic            pin_out,
  output logic            busy_out
);
  logic [4:0] left_r;
  logic [3:0] hold_r;

  initial begin
    pin_out  = 1'b0;
    busy_out = 1'b0;
    left_r   = 5'h00;
    hold_r   = 4'h0;
  end

  // Pin is driven from here only while pin_dir_out_r is low
  // Width of 2 or more keeps each level visible to the synchroniser
  always @(posedge clk_in) begin
    if (start_in && !busy_out) begin
      busy_out <= 1'b1;
      left_r   <= count_in;
      hold_r   <= width_in;
      pin_out  <= 1'b1;
    end else if (busy_out) begin
      if (hold_r > 4'h1) begin
        hold_r <= hold_r - 4'h1;
      end else begin
        hold_r <= width_in;
        if (pin_out) begin
          pin_out <= 1'b0;
        end else if (left_r > 5'h01) begin
          pin_out <= 1'b1;
          left_r  <= left_r - 5'h01;
        end else begin
          busy_out <= 1'b0;
        end
      end
    end
  end
endmodule // ccu_pin_src

// [verif/ccu_top_test.sv]
`timescale 1ns/1ns
module ccu_top_test;
  logic        clk_in, sys_rst_in, reg_wr_in, reg_rd_in;
  logic [2:0]  reg_addr_in;
  logic [7:0]  reg_wdata_in, reg_rdata_out, rd_data;
  logic [15:0] timer_count_in;
  logic        timer_tick_in, adc_enabled_in, timer_reset_out, special_trig_out;
  logic        adc_start_out, pin_in, port_latch_in, pin_out, pin_owned_out;
  logic [9:0]  pwm_duty_out;
  logic        event_flag_out, src_start_r, src_pin, src_busy, pin_dir_out_r;
  logic [4:0]  src_count_r;
  logic [3:0]  src_width_r;
  logic        t_seen, a_seen, r_seen;
  int          fail_count;
  int          samples_checked;

  // Pin level follows the port latch while software makes it an output
  assign pin_in = pin_dir_out_r ? pin_out : src_pin;

  ccu_top i_dut (
    .clk_in           (clk_in),
    .sys_rst_in       (sys_rst_in),
    .reg_addr_in      (reg_addr_in),
    .reg_wdata_in     (reg_wdata_in),
    .reg_wr_in        (reg_wr_in),
    .reg_rd_in        (reg_rd_in),
    .reg_rdata_out    (reg_rdata_out),
    .timer_count_in   (timer_count_in),
    .timer_tick_in    (timer_tick_in),
    .adc_enabled_in   (adc_enabled_in),
    .timer_reset_out  (timer_reset_out),
    .special_trig_out (special_trig_out),
    .adc_start_out    (adc_start_out),
    .pin_in           (pin_in),
    .port_latch_in    (port_latch_in),
    .pin_out          (pin_out),
    .pin_owned_out    (pin_owned_out),
    .pwm_duty_out     (pwm_duty_out),
    .event_flag_out   (event_flag_out)
  );

  ccu_pin_src i_src (
    .clk_in   (clk_in),
    .start_in (src_start_r),
    .count_in (src_count_r),
    .width_in (src_width_r),
    .pin_out  (src_pin),
    .busy_out (src_busy)
  );

  task automatic results();
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // Gap cycle after each strobe keeps one driver assignment per edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rd(input logic [2:0] a);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 rd_data = reg_rdata_out;
    @(posedge clk_in);
  endtask

  task automatic rdcap(input logic [15:0] exp);
    logic [7:0] lo;
    rd(ccu_pkg::ADDR_CAP_LO);
    lo = rd_data;
    rd(ccu_pkg::ADDR_CAP_HI);
    chk("capture", exp, {rd_data, lo});
  endtask

  task automatic pulse(input logic [4:0] n, input logic [3:0] w);
    src_count_r <= n;
    src_width_r <= w;
    src_start_r <= 1'b1;
    @(posedge clk_in);
    src_start_r <= 1'b0;
    // Busy rises only after the edge that takes the start
    @(posedge clk_in);
    for (int i = 0; i < 400 && src_busy !== 1'b0; i++) @(posedge clk_in);
    if (src_busy !== 1'b0) begin
      fail_count++;
      results();
    end
    cyc(6);
  endtask

  // Mode change may leave a false event behind, so the flag is cleared
  task automatic mode(input logic [7:0] c);
    wr(ccu_pkg::ADDR_CTRL, c);
    wr(ccu_pkg::ADDR_FLAG, 8'h00);
  endtask

  task automatic watch(input int n);
    repeat (n) begin
      @(posedge clk_in);
      // A tick lasts one cycle; the reset pulse it causes is caught here
      timer_tick_in <= 1'b0;
      #1 t_seen = t_seen | special_trig_out;
      a_seen = a_seen | adc_start_out;
      r_seen = r_seen | timer_reset_out;
    end
    @(posedge clk_in);
  endtask

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  initial begin
    {reg_wr_in, reg_rd_in, timer_tick_in, port_latch_in, src_start_r} = 5'h00;
    {adc_enabled_in, pin_dir_out_r, t_seen, a_seen, r_seen} = 5'h00;
    {reg_addr_in, reg_wdata_in, timer_count_in} = 27'h0;
    {src_count_r, src_width_r} = 9'h000;
    fail_count = 0;
    samples_checked = 0;
    sys_rst_in = 1'b1;
    cyc(8);
    sys_rst_in <= 1'b0;
    cyc(1);
    rd(ccu_pkg::ADDR_CTRL);
    chk("ctrl reset", 16'h0000, {8'h00, rd_data});
    wr(ccu_pkg::ADDR_CTRL, 8'hE0);
    wr(ccu_pkg::ADDR_DUTY_HI, 8'hA5);
    rd(ccu_pkg::ADDR_CTRL);
    chk("ctrl read", 16'h0020, {8'h00, rd_data});
    chk("pwm duty", 16'h0296, {6'h00, pwm_duty_out});
    timer_count_in <= 16'h1234; // Same-clock timer
    mode(8'h05);
    pulse(5'h01, 4'h3);
    rdcap(16'h1234);
    chk("flag rise", 16'h0001, {15'h0, event_flag_out});
    timer_count_in <= 16'hBEEF;
    pulse(5'h01, 4'h3);
    rdcap(16'hBEEF);
    chk("flag kept", 16'h0001, {15'h0, event_flag_out});
    mode(8'h04);
    timer_count_in <= 16'h4321;
    pin_dir_out_r <= 1'b1;
    port_latch_in <= 1'b1;
    cyc(8);
    chk("flag no fall", 16'h0000, {15'h0, event_flag_out});
    port_latch_in <= 1'b0;
    cyc(8);
    chk("flag fall", 16'h0001, {15'h0, event_flag_out});
    rdcap(16'h4321);
    pin_dir_out_r <= 1'b0;
    mode(8'h06);
    pulse(5'h02, 4'h3);
    mode(8'h00);
    mode(8'h06);
    pulse(5'h03, 4'h3);
    chk("div4 early", 16'h0000, {15'h0, event_flag_out});
    pulse(5'h01, 4'h3);
    chk("div4 fourth", 16'h0001, {15'h0, event_flag_out});
    mode(8'h00);
    mode(8'h07);
    pulse(5'h0F, 4'hA);
    chk("div16 early", 16'h0000, {15'h0, event_flag_out});
    pulse(5'h01, 4'h2);
    chk("div16 last", 16'h0001, {15'h0, event_flag_out});
    timer_count_in <= 16'h0000;
    wr(ccu_pkg::ADDR_CMP_LO, 8'h00);
    wr(ccu_pkg::ADDR_CMP_HI, 8'h02);
    mode(8'h08);
    timer_count_in <= 16'h0200;
    cyc(5);
    chk("set pin", 16'h0003, {14'h0, pin_owned_out, pin_out});
    chk("set flag", 16'h0001, {15'h0, event_flag_out});
    timer_count_in <= 16'h0000;
    mode(8'h09);
    timer_count_in <= 16'h0200;
    cyc(5);
    chk("clr pin", 16'h0002, {14'h0, pin_owned_out, pin_out});
    chk("clr flag", 16'h0001, {15'h0, event_flag_out});
    timer_count_in <= 16'h0000;
    port_latch_in <= 1'b1;
    mode(8'h00);
    chk("off pin", 16'h0001, {14'h0, pin_owned_out, pin_out});
    mode(8'h0A);
    timer_count_in <= 16'h0200;
    cyc(5);
    chk("sw pin", 16'h0001, {14'h0, pin_owned_out, pin_out});
    chk("sw flag", 16'h0001, {15'h0, event_flag_out});
    timer_count_in <= 16'h0000;
    adc_enabled_in <= 1'b1;
    mode(8'h0B);
    timer_count_in <= 16'h0200;
    watch(4);
    chk("trig adc rst", 16'h0006, {13'h0, t_seen, a_seen, r_seen});
    chk("trig flag", 16'h0001, {15'h0, event_flag_out});
    timer_tick_in <= 1'b1;
    watch(3);
    chk("timer reset", 16'h0001, {15'h0, r_seen});
    results();
  end
endmodule // ccu_top_test
